// ### logic/cdi_host.sv
// Host end: configuration source with APB command registers
`timescale 1ns/1ps
`default_nettype none
module cdi_host #(
  parameter logic CLK_IDLE_LEVEL = 1'b0
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  cdi_link_if.host link
);
  import cdi_pkg::*;

  cdi_hstate_t state;
  cdi_mode_t mode;
  logic start;
  logic pending;
  logic [7:0] data_reg;
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic [7:0] cnt;
  logic clk_o;
  logic wr_n;
  logic rs_n;
  logic d7_en;
  logic [2:0] in_m;
  logic [2:0] in_s;
  logic config_clock_q;
  logic done_s;
  logic acc;
  logic mapped;
  logic wr_fire;
  logic sent;
  logic as_fall;
  logic last;

  // ==========================================
  // APB slave
  assign acc = psel & penable;
  assign mapped = paddr == REG_CTRL || paddr == REG_STATUS ||
                  paddr == REG_DATA;
  assign pready = !(acc && pwrite && paddr == REG_DATA && pending);
  assign pslverr = acc & ~mapped;
  assign wr_fire = acc & pwrite & pready & mapped;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0;
    end else if (psel && !penable) begin
      if (paddr == REG_CTRL) begin
        prdata <= {29'h0, mode, start};
      end else if (paddr == REG_STATUS) begin
        prdata <= {29'h0, start, done_s, pending};
      end else begin
        prdata <= 32'h0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      start <= 1'b0;
      mode <= CDI_PS;
    end else if (wr_fire && paddr == REG_CTRL) begin
      start <= pwdata[CTRL_START];
      mode <= cdi_mode_t'(pwdata[CTRL_MODE_MSB:CTRL_MODE_LSB]);
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pending <= 1'b0;
      data_reg <= 8'h00;
    end else if (wr_fire && paddr == REG_DATA) begin
      pending <= 1'b1;
      data_reg <= pwdata[BYTE_W-1:0];
    end else if (sent) begin
      pending <= 1'b0;
    end
  end

  // ==========================================
  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      in_m <= 3'h0;
      in_s <= 3'h0;
      config_clock_q <= 1'b0;
    end else begin
      in_m <= {link.config_complete, link.data_level[MSB], link.clk_level};
      in_s <= in_m;
      config_clock_q <= in_s[0];
    end
  end

  assign done_s = in_s[2];
  assign as_fall = mode == CDI_AS && config_clock_q && !in_s[0];
  assign last = cnt == LINK_HALF_CYC - 8'h01;
  assign sent = (state == HS_PULSE && last && mode != CDI_PPA &&
                 (mode == CDI_FPP || bitcnt == LAST_BIT)) ||
                (state == HS_HOLD && last) ||
                (as_fall && pending && bitcnt == LAST_BIT);

  // ==========================================
  // Link sequencer
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= HS_IDLE;
      shreg <= 8'h00;
      bitcnt <= 3'h0;
      cnt <= 8'h00;
      clk_o <= 1'b1;
      wr_n <= 1'b1;
      rs_n <= 1'b1;
      d7_en <= 1'b0;
    end else begin
      case (state)
        HS_IDLE: begin
          cnt <= 8'h00;
          d7_en <= 1'b0;
          if (mode == CDI_AS) begin
            if (wr_fire && paddr == REG_DATA) begin
              shreg <= pwdata[BYTE_W-1:0];
              bitcnt <= 3'h0;
            end else if (as_fall && pending) begin
              shreg <= {1'b0, shreg[MSB:1]};
              bitcnt <= bitcnt + 3'h1;
            end
          end else if (start && pending && !done_s) begin
            shreg <= data_reg;
            bitcnt <= 3'h0;
            if (mode == CDI_PPA) begin
              rs_n <= 1'b0;
              state <= HS_POLL;
            end else begin
              state <= HS_SETUP;
            end
          end
        end
        HS_POLL: begin
          if (cnt < SYNC_WAIT_CYC) begin
            cnt <= cnt + 8'h01;
          end else if (in_s[1]) begin
            rs_n <= 1'b1;
            cnt <= 8'h00;
            state <= HS_SETUP;
          end
        end
        HS_SETUP: begin
          clk_o <= 1'b0;
          cnt <= cnt + 8'h01;
          if (last) begin
            cnt <= 8'h00;
            clk_o <= 1'b1;
            wr_n <= mode != CDI_PPA;
            d7_en <= 1'b1;
            state <= HS_PULSE;
          end
        end
        HS_PULSE: begin
          cnt <= cnt + 8'h01;
          if (last) begin
            cnt <= 8'h00;
            if (mode == CDI_PPA) begin
              wr_n <= 1'b1;
              state <= HS_HOLD;
            end else if (mode == CDI_PS && bitcnt != LAST_BIT) begin
              shreg <= {1'b0, shreg[MSB:1]};
              bitcnt <= bitcnt + 3'h1;
              state <= HS_SETUP;
            end else begin
              state <= HS_IDLE;
            end
          end
        end
        HS_HOLD: begin
          cnt <= cnt + 8'h01;
          if (last) begin
            state <= HS_IDLE;
          end
        end
        default: begin
          state <= HS_IDLE;
        end
      endcase
    end
  end

  // ==========================================
  // Pin drive
  assign link.host_clk_oe = start && (mode != CDI_AS || done_s);
  assign link.host_clk_o = done_s ? CLK_IDLE_LEVEL :
                           (mode == CDI_PPA ? 1'b1 : clk_o);
  assign link.host_data_o = (mode == CDI_FPP || mode == CDI_PPA) ?
                            shreg : {7'h00, shreg[0]};
  assign link.host_data_oe[0] = start && !done_s;
  assign link.host_data_oe[MSB-1:1] = {(MSB-1){start && !done_s &&
    (mode == CDI_FPP || mode == CDI_PPA)}};
  assign link.host_data_oe[MSB] = start && !done_s &&
    (mode == CDI_FPP || (mode == CDI_PPA && d7_en));
  assign link.wr_strobe_n = wr_n;
  assign link.status_read_strobe_n = rs_n;
  assign link.select_low = ~start;
  assign link.select_high = start;
endmodule : cdi_host
`default_nettype wire

// ### logic/cdi_pkg.sv
// Shared types and constants of the configuration data input port
// Summary of operation
// - Passive serial and fast parallel capture on external clock rise
// - Active serial: device drives configuration clock
// - Host holds clock high in async parallel
// - Device releases clock pin after configuration
// - Memory source drives clock low afterwards
// - Host holds clock fixed level afterwards
// - Clock edges ignored after configuration
// - Serial modes: one bit on serial pin
// - Serial pin released to user afterwards
// - Parallel modes: one byte on eight pins
// - Serial modes: upper data pins stay released
// - Upper data pins released after parallel load
// - Read strobe low puts status on top pin
// - Serial modes: top data pin stays released
// - Top data pin released after async parallel
// - Write strobe rise captures the byte
// - Write strobe unused outside async parallel
// - Write strobe released after async parallel
// - Status high ready, low busy
// - Host holds both selects active throughout
// - Complete output low until all data arrives
package cdi_pkg;
  // ==========================================
  // Modes and states
  typedef enum logic [1:0] {
    CDI_PS = 2'h0, CDI_FPP = 2'h1, CDI_PPA = 2'h2, CDI_AS = 2'h3
  } cdi_mode_t;
  typedef enum logic [1:0] {
    DS_LOAD = 2'h0, DS_INIT = 2'h1, DS_USER = 2'h3
  } cdi_dstate_t;
  typedef enum logic [2:0] {
    HS_IDLE = 3'h0, HS_SETUP = 3'h1, HS_PULSE = 3'h3, HS_HOLD = 3'h2,
    HS_POLL = 3'h6
  } cdi_hstate_t;
  // ==========================================
  // Timing
  localparam int CLK_NS = 10;
  localparam int LINK_CLK_NS = 80;
  localparam int AS_CLK_NS = 160;
  localparam int BUSY_NS = 100;
  localparam logic [7:0] LINK_HALF_CYC = 8'(LINK_CLK_NS / (2 * CLK_NS));
  localparam logic [7:0] AS_HALF_CYC = 8'(AS_CLK_NS / (2 * CLK_NS));
  localparam logic [7:0] BUSY_CYC = 8'((BUSY_NS + CLK_NS - 1) / CLK_NS);
  localparam logic [7:0] SYNC_WAIT_CYC = 8'h04;
  // ==========================================
  // Data layout
  localparam int BYTE_W = 8;
  localparam int MSB = 7;
  localparam logic [2:0] LAST_BIT = 3'h7;
  // ==========================================
  // Host register map
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam logic [7:0] REG_DATA = 8'h08;
  localparam int CTRL_START = 0;
  localparam int CTRL_MODE_LSB = 1;
  localparam int CTRL_MODE_MSB = 2;
  localparam int STAT_BUSY = 0;
  localparam int STAT_DONE = 1;
  localparam int STAT_START = 2;
endpackage : cdi_pkg

// ### logic/cdi_link_if.sv
// Configuration link between device and host with pin resolution
`timescale 1ns/1ps
`default_nettype none
interface cdi_link_if;
  import cdi_pkg::*;
  logic dev_clk_o;
  logic dev_clk_oe;
  logic host_clk_o;
  logic host_clk_oe;
  logic clk_level;
  logic [7:0] host_data_o;
  logic [7:0] host_data_oe;
  logic dev_d7_o;
  logic dev_d7_oe;
  logic [7:0] data_level;
  logic wr_strobe_n;
  logic status_read_strobe_n;
  logic select_low;
  logic select_high;
  logic dev_done_oe;
  logic config_complete;
  // ==========================================
  // Wire levels, pull-ups when undriven
  assign clk_level = dev_clk_oe ? dev_clk_o :
                     (host_clk_oe ? host_clk_o : 1'b1);
  assign data_level[MSB-1:0] = host_data_o[MSB-1:0] |
                               ~host_data_oe[MSB-1:0];
  assign data_level[MSB] = dev_d7_oe ? dev_d7_o :
                           (host_data_oe[MSB] ? host_data_o[MSB] : 1'b1);
  assign config_complete = ~dev_done_oe;
  modport dev (
    input clk_level, data_level, wr_strobe_n, status_read_strobe_n,
    input select_low, select_high,
    output dev_clk_o, dev_clk_oe, dev_d7_o, dev_d7_oe, dev_done_oe
  );
  modport host (
    input clk_level, data_level, config_complete,
    output host_clk_o, host_clk_oe, host_data_o, host_data_oe,
    output wr_strobe_n, status_read_strobe_n, select_low, select_high
  );
endinterface : cdi_link_if
`default_nettype wire

// ### logic/cdi_dev.sv
// Device end: configuration data input port
`timescale 1ns/1ps
`default_nettype none
module cdi_dev #(
  parameter int CFG_BYTES = 16,
  parameter int INIT_CYC = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire cdi_pkg::cdi_mode_t mode,
  cdi_link_if.dev link,
  output logic [7:0] cfg_byte,
  output logic cfg_byte_valid,
  output logic ready_not_busy,
  output logic user_mode
);
  import cdi_pkg::*;

  cdi_dstate_t state;
  logic [3:0] ctl_m;
  logic [3:0] ctl_s;
  logic [7:0] data_m;
  logic [7:0] data_s;
  logic clk_q;
  logic wr_q;
  logic clk_rise;
  logic wr_rise;
  logic sel_s;
  logic rs_low_s;
  logic loading;
  logic [7:0] as_cnt;
  logic as_clk;
  logic as_rise;
  logic take_bit;
  logic take_byte;
  logic [7:0] shreg;
  logic [2:0] bitcnt;
  logic [15:0] byte_cnt;
  logic byte_done;
  logic [7:0] byte_val;
  logic busy;
  logic [7:0] busy_cnt;
  logic [15:0] init_cnt;
  logic wr_m;
  logic wr_s;

  // ==========================================
  // Pin synchronisers
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      // Idle clock level is high: no false rise after reset
      ctl_m <= 4'h1;
      ctl_s <= 4'h1;
      data_m <= 8'h00;
      data_s <= 8'h00;
    end else begin
      ctl_m <= {link.select_high, ~link.select_low,
                ~link.status_read_strobe_n, link.clk_level};
      ctl_s <= ctl_m;
      data_m <= link.data_level;
      data_s <= data_m;
    end
  end

  // ==========================================
  // Edge detection
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clk_q <= 1'b1;
      wr_q <= 1'b1;
    end else begin
      clk_q <= ctl_s[0];
      wr_q <= wr_s;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wr_m <= 1'b1;
      wr_s <= 1'b1;
    end else begin
      wr_m <= link.wr_strobe_n;
      wr_s <= wr_m;
    end
  end

  assign loading = (state == DS_LOAD);
  assign rs_low_s = ctl_s[1];
  assign sel_s = ctl_s[2] & ctl_s[3];
  assign clk_rise = ctl_s[0] & ~clk_q;
  assign wr_rise = wr_s & ~wr_q;

  // ==========================================
  // Active serial clock divider
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      as_cnt <= 8'h00;
      as_clk <= 1'b0;
    end else if (loading && mode == CDI_AS) begin
      if (as_cnt == AS_HALF_CYC - 8'h01) begin
        as_cnt <= 8'h00;
        as_clk <= ~as_clk;
      end else begin
        as_cnt <= as_cnt + 8'h01;
      end
    end else begin
      as_cnt <= 8'h00;
      as_clk <= 1'b0;
    end
  end

  assign as_rise = loading && mode == CDI_AS && ~as_clk &&
                   as_cnt == AS_HALF_CYC - 8'h01;
  assign link.dev_clk_o = as_clk;
  assign link.dev_clk_oe = loading && mode == CDI_AS;

  // ==========================================
  // Capture events, only while loading
  assign take_bit = loading &&
    ((mode == CDI_PS && clk_rise) || as_rise);
  assign take_byte = loading &&
    ((mode == CDI_FPP && clk_rise) ||
     (mode == CDI_PPA && wr_rise && sel_s && !busy));

  // ==========================================
  // Serial shift and byte assembly
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shreg <= 8'h00;
      bitcnt <= 3'h0;
    end else if (!loading) begin
      bitcnt <= 3'h0;
    end else if (take_bit) begin
      shreg <= {data_s[0], shreg[MSB:1]};
      bitcnt <= bitcnt + 3'h1;
    end
  end

  assign byte_done = take_byte || (take_bit && bitcnt == LAST_BIT);
  assign byte_val = take_byte ? data_s : {data_s[0], shreg[MSB:1]};

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg_byte <= 8'h00;
      cfg_byte_valid <= 1'b0;
    end else begin
      cfg_byte_valid <= byte_done;
      if (byte_done) begin
        cfg_byte <= byte_val;
      end
    end
  end

  // ==========================================
  // Ready and busy after each async parallel byte
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      busy <= 1'b0;
      busy_cnt <= 8'h00;
    end else if (take_byte && mode == CDI_PPA) begin
      busy <= 1'b1;
      busy_cnt <= BUSY_CYC;
    end else if (busy_cnt > 8'h01) begin
      busy_cnt <= busy_cnt - 8'h01;
    end else begin
      busy_cnt <= 8'h00;
      busy <= 1'b0;
    end
  end

  assign ready_not_busy = ~busy;

  // ==========================================
  // Status readback on top data pin
  assign link.dev_d7_o = ready_not_busy;
  assign link.dev_d7_oe = mode == CDI_PPA && state != DS_USER &&
                          rs_low_s && sel_s;

  // ==========================================
  // Load, initialisation and user mode
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= DS_LOAD;
      byte_cnt <= 16'h0000;
      init_cnt <= 16'h0000;
    end else begin
      case (state)
        DS_LOAD: begin
          if (byte_done) begin
            if (byte_cnt == 16'(CFG_BYTES - 1)) begin
              state <= DS_INIT;
            end
            byte_cnt <= byte_cnt + 16'h0001;
          end
        end
        DS_INIT: begin
          if (init_cnt == 16'(INIT_CYC - 1)) begin
            state <= DS_USER;
          end
          init_cnt <= init_cnt + 16'h0001;
        end
        DS_USER: begin
          state <= DS_USER;
        end
        default: begin
          state <= DS_LOAD;
        end
      endcase
    end
  end

  assign link.dev_done_oe = loading;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      user_mode <= 1'b0;
    end else begin
      user_mode <= (state == DS_USER);
    end
  end
endmodule : cdi_dev
`default_nettype wire

// ### sim/cdi_link_asserts.sv
// Checker for the configuration link between the two ends
`timescale 1ns/1ps
`default_nettype none
module cdi_link_asserts #(
  parameter int INIT_CYC = 20
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire cdi_pkg::cdi_mode_t mode,
  input wire logic user_mode,
  input wire logic cfg_byte_valid,
  input wire logic ready_not_busy,
  input wire logic dev_clk_o,
  input wire logic dev_clk_oe,
  input wire logic dev_d7_o,
  input wire logic dev_d7_oe,
  input wire logic wr_strobe_n,
  input wire logic status_read_strobe_n,
  input wire logic config_complete
);
  import cdi_pkg::*;
  localparam int INIT_MAX = INIT_CYC + 8;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // ==========================================
  // Clock pin
  clk_drive_a : assert property (
    dev_clk_oe |-> mode == CDI_AS && !user_mode)
    else $error("device clock driven outside load");
  clk_period_a : assert property (
    $rose(dev_clk_o) && dev_clk_oe |=> (dev_clk_o || !dev_clk_oe)[*7])
    else $error("device clock high phase too short");
  // ==========================================
  // Status pin
  top_pin_mode_a : assert property (
    dev_d7_oe |-> mode == CDI_PPA && !user_mode)
    else $error("top data pin driven out of mode");
  rs_release_a : assert property (
    status_read_strobe_n [*5] |-> !dev_d7_oe)
    else $error("top data pin driven without read strobe");
  busy_on_take_a : assert property (
    cfg_byte_valid && mode == CDI_PPA |-> !ready_not_busy)
    else $error("status ready right after a parallel byte");
  busy_refuse_a : assert property (
    !ready_not_busy && !$past(ready_not_busy) |-> !cfg_byte_valid)
    else $error("byte taken while busy");
  busy_bound_a : assert property (
    $fell(ready_not_busy) |-> (!ready_not_busy) [*8] ##[1:4] ready_not_busy)
    else $error("busy time out of bounds");
  // ==========================================
  // Capture and completion
  strobe_capture_a : assert property (
    $rose(wr_strobe_n) && mode == CDI_PPA && ready_not_busy &&
    !config_complete |-> ##[1:6] cfg_byte_valid)
    else $error("write strobe rise captured nothing");
  frozen_a : assert property (
    user_mode |=> user_mode && !cfg_byte_valid)
    else $error("configured state changed");
  done_order_a : assert property (
    $rose(user_mode) |-> config_complete)
    else $error("user mode before completion");
  init_bound_a : assert property (
    $rose(config_complete) |-> ##[1:INIT_MAX] user_mode)
    else $error("no user mode after completion");
endmodule : cdi_link_asserts
`default_nettype wire

// ### sim/testbench.sv
// Testbench joining device end and host end over the link
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import cdi_pkg::*;
  localparam int NBYTES = 3;
  localparam int INIT_N = 4;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  cdi_mode_t mode = CDI_PS;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [7:0] cfg_byte;
  logic cfg_byte_valid;
  logic ready_not_busy;
  logic user_mode;
  logic [7:0] got[$];
  logic [7:0] pat[NBYTES] = '{8'ha5, 8'h3c, 8'h81};
  logic d7_seen = 1'b0;
  logic busy_seen = 1'b0;
  int fail_count = 0;
  int samples_checked = 0;
  int cycles = 0;
  cdi_link_if link ();
  cdi_dev #(.CFG_BYTES(NBYTES), .INIT_CYC(INIT_N)) u_cdi_dev (
    .pclk(pclk), .presetn(presetn), .mode(mode), .link(link),
    .cfg_byte(cfg_byte), .cfg_byte_valid(cfg_byte_valid),
    .ready_not_busy(ready_not_busy), .user_mode(user_mode));
  cdi_host u_cdi_host (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .link(link));
  cdi_link_asserts #(.INIT_CYC(INIT_N)) u_cdi_link_asserts (
    .pclk(pclk), .presetn(presetn), .mode(mode), .user_mode(user_mode),
    .cfg_byte_valid(cfg_byte_valid), .ready_not_busy(ready_not_busy),
    .dev_clk_o(link.dev_clk_o), .dev_clk_oe(link.dev_clk_oe),
    .dev_d7_o(link.dev_d7_o), .dev_d7_oe(link.dev_d7_oe),
    .wr_strobe_n(link.wr_strobe_n),
    .status_read_strobe_n(link.status_read_strobe_n),
    .config_complete(link.config_complete));
  always #5 pclk = ~pclk;
  // ==========================================
  // Monitor and watchdog
  always @(posedge pclk) begin
    if (cfg_byte_valid === 1'b1) got.push_back(cfg_byte);
    if (link.dev_d7_oe === 1'b1) d7_seen = 1'b1;
    if (ready_not_busy === 1'b0) busy_seen = 1'b1;
    cycles++;
    if (cycles == 20000) begin
      fail_count++;
      stop_test();
    end
  end
  // ==========================================
  // Shared tasks
  task automatic stop_test();
    $display("checks %0d mismatches %0d", samples_checked, fail_count);
    if (fail_count == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask : stop_test
  task automatic check(input string what, input logic [31:0] exp,
                       input logic [31:0] seen);
    samples_checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask : check
  task automatic apb(input logic wr, input logic [7:0] addr,
                     input logic [31:0] wd, output logic [31:0] rd,
                     output logic err);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= addr;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic do_reset(input cdi_mode_t m);
    presetn <= 1'b0;
    mode <= m;
    repeat (10) @(posedge pclk);
    presetn <= 1'b1;
    got.delete();
    d7_seen = 1'b0;
    busy_seen = 1'b0;
  endtask : do_reset
  task automatic load(input cdi_mode_t m);
    logic [31:0] rd;
    logic err;
    do_reset(m);
    apb(1'b1, REG_CTRL, (32'(m) << CTRL_MODE_LSB) | 32'h1, rd, err);
    apb(1'b1, REG_DATA, 32'(pat[0]), rd, err);
    repeat (2) @(posedge pclk);
  endtask : load
  task automatic finish_load(input logic cmp);
    logic [31:0] rd;
    logic err;
    int n;
    for (int i = 1; i < NBYTES; i++) begin
      apb(1'b1, REG_DATA, 32'(pat[i]), rd, err);
      check("config_complete", 32'h0, 32'(link.config_complete));
    end
    n = 0;
    while (user_mode !== 1'b1 && n < 3000) begin
      @(posedge pclk);
      n++;
    end
    repeat (8) @(posedge pclk);
    apb(1'b0, REG_STATUS, 32'h0, rd, err);
    check("status_done", 32'h1, 32'(rd[STAT_DONE]));
    check("user_mode", 32'h1, 32'(user_mode));
    check("clk_oe", 32'h0, 32'(link.dev_clk_oe));
    check("clk_level", 32'h0, 32'(link.clk_level));
    check("top_oe", 32'h0, 32'(link.dev_d7_oe));
    check("data_oe", 32'h0, 32'(link.host_data_oe));
    check("byte_count", NBYTES, 32'(got.size()));
    for (int i = 0; i < NBYTES && cmp; i++) begin
      check("cfg_byte", 32'(pat[i]), 32'(got[i]));
    end
  endtask : finish_load
  // ==========================================
  // Scenarios
  task automatic test_regs();
    logic [31:0] rd;
    logic err;
    do_reset(CDI_PS);
    check("ready_reset", 32'h1, 32'(ready_not_busy));
    apb(1'b0, REG_STATUS, 32'h0, rd, err);
    check("status_reset", 32'h0, rd);
    apb(1'b0, 8'h0c, 32'h0, rd, err);
    check("unmapped_err", 32'h1, 32'(err));
    check("unmapped_data", 32'h0, rd);
    apb(1'b0, REG_DATA, 32'h0, rd, err);
    check("data_read", 32'h0, rd);
    apb(1'b1, REG_CTRL, 32'h1, rd, err);
    apb(1'b0, REG_STATUS, 32'h0, rd, err);
    check("status_start", 32'h1, 32'(rd[STAT_START]));
    check("status_err", 32'h0, 32'(err));
    apb(1'b0, REG_CTRL, 32'h0, rd, err);
    check("ctrl_read", 32'h1, rd);
    check("config_complete", 32'h0, 32'(link.config_complete));
    $display("test registers done");
  endtask : test_regs
  task automatic test_ps();
    load(CDI_PS);
    check("upper_oe", 32'h0, 32'(link.host_data_oe[7:1]));
    check("clk_oe", 32'h0, 32'(link.dev_clk_oe));
    finish_load(1'b1);
    $display("test passive serial done");
  endtask : test_ps
  task automatic test_fpp();
    load(CDI_FPP);
    check("data_oe", 32'hff, 32'(link.host_data_oe));
    finish_load(1'b1);
    $display("test fast parallel done");
  endtask : test_fpp
  task automatic test_ppa();
    load(CDI_PPA);
    check("clk_level", 32'h1, 32'(link.clk_level));
    check("select_low", 32'h0, 32'(link.select_low));
    check("select_high", 32'h1, 32'(link.select_high));
    finish_load(1'b1);
    check("status_driven", 32'h1, 32'(d7_seen));
    check("busy_seen", 32'h1, 32'(busy_seen));
    $display("test async parallel done");
  endtask : test_ppa
  task automatic test_as();
    load(CDI_AS);
    repeat (20) @(posedge pclk);
    check("clk_oe", 32'h1, 32'(link.dev_clk_oe));
    finish_load(1'b0);
    $display("test active serial done");
  endtask : test_as
  initial begin
    test_regs();
    test_ps();
    test_fpp();
    test_ppa();
    test_as();
    stop_test();
  end
endmodule : testbench
`default_nettype wire
